// ---- core/vme_bridge_defines.svh ----
// register map, field positions and reset values of the bridge control block
`ifndef VME_BRIDGE_DEFINES_SVH
`define VME_BRIDGE_DEFINES_SVH
`define OFF_CTRL_STATUS 12'h000
`define OFF_CONFIG      12'h004
`define OFF_ADDR_EXT    12'h008
`define OFF_MAP_INDEX   12'h00c
`define OFF_MAP_DATA    12'h010
`define CS_WWP          3
`define CS_SLAVE_PARITY_ERROR_ENABLE        2
`define CS_LDV          1
`define CS_VDV          0
`define CS_RESET        4'h0
`define EXT_RESET       8'h00
`define IDX_RESET       12'h000
`define TBL_HI          11
`define TBL_LO          10
`define TBL_LOCAL       2'h0
`define TBL_A32         2'h1
`define TBL_A24         2'h2
`define SEG_HI          31
`define SEG_LO          22
`define AM_A16          2'h0
`define AM_A24          2'h1
`define AM_A32          2'h2
`define A16_OUT_TAG     16'hffff
`define A16_IN_TAG      16'hfffe
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define RESP_DECERR     2'h3
`endif

// ---- core/vme_bridge_pkg.sv ----
// types shared by the bridge control block
package vme_bridge_pkg;
	typedef enum logic [2:0] {SP_UTILITY, SP_DRAM, SP_A32, SP_A24, SP_A16} space_t;
	typedef enum logic [1:0] {SLV_IDLE, SLV_WAIT_GNT, SLV_XFER, SLV_DONE} slv_state_t;
endpackage : vme_bridge_pkg

// ---- core/vme_local_bus_bridge_control.sv ----
// local memory bus to vmebus bridge control: arbiter, decoders, control register
`timescale 1ns/1ps
`include "vme_bridge_defines.svh"
// Behaviour
// - grant vme slave, code units, data units
// - vme requests unfair, cache units fair
// - config status shows bus acknowledge lines
// - outbound access classified A32, A24, A16
// - board base on any 4MB boundary
// - A24 inbound gets upper byte from extension
// - per segment snoop bit requests snooping
// - master: no unaligned, no block transfers
// - slave: unaligned, address-only ok, block refused
// - registers 32-bit words on 4-byte boundaries
// - undefined bits read one, writes ignored
// - control register zeroed by any reset
// - wrong parity bit inverts cpu write parity
// - vme writes even parity, reads checked even
// - decoder invalid maps all but A16 tag addresses to utility
// - vme decoder invalid blocks A24/A32 response
// - after reset everything but A16 tag addresses maps to utility
module vme_local_bus_bridge_control
	import vme_bridge_pkg::*;
(
	// clock, reset, enable
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          ce,
	input  wire logic                          system_reset,
	input  wire logic                          local_reset,
	// axi4-lite slave
	input  wire logic [11:0]                   s_awaddr,
	input  wire logic                          s_awvalid,
	output logic                               s_awready,
	input  wire logic [31:0]                   s_wdata,
	input  wire logic [3:0]                    s_wstrb,
	input  wire logic                          s_wvalid,
	output logic                               s_wready,
	output logic [1:0]                         s_bresp,
	output logic                               s_bvalid,
	input  wire logic                          s_bready,
	input  wire logic [11:0]                   s_araddr,
	input  wire logic                          s_arvalid,
	output logic                               s_arready,
	output logic [31:0]                        s_rdata,
	output logic [1:0]                         s_rresp,
	output logic                               s_rvalid,
	input  wire logic                          s_rready,
	// local bus arbitration
	input  wire logic [3:0]                    code_req,
	input  wire logic [3:0]                    data_req,
	output logic [8:0]                         bus_grant,
	// outbound decode
	input  wire logic                          out_valid,
	input  wire logic [31:0]                   out_addr,
	input  wire logic [1:0]                    out_size,
	input  wire logic                          out_block,
	input  wire logic                          out_cpu_write,
	output logic                               out_done,
	output vme_bridge_pkg::space_t             out_space,
	output logic                               out_fault,
	output logic                               out_parity_odd,
	// vmebus slave pins
	input  wire logic                          vme_strobe,
	input  wire logic                          vme_write,
	input  wire logic                          vme_addr_only,
	input  wire logic                          vme_block,
	input  wire logic [1:0]                    vme_am,
	input  wire logic [31:0]                   vme_addr,
	input  wire logic [3:0]                    vme_lanes,
	input  wire logic [7:0]                    ack_lines,
	output logic                               vme_dtack,
	output logic                               vme_berr,
	// local memory side of inbound access
	output logic                               mem_req,
	output logic [31:0]                        mem_addr,
	output logic [3:0]                         mem_be,
	output logic                               mem_write,
	output logic                               mem_snoop,
	output logic                               mem_parity_odd,
	input  wire logic                          mem_done,
	input  wire logic [31:0]                   mem_rdata,
	input  wire logic [3:0]                    mem_rpar
);
	import vme_bridge_pkg::*;

	logic [3:0]  ctrl;
	logic [7:0]  addr_ext;
	logic [11:0] map_index;
	logic [1:0]  local_map [1024];
	logic [1:0]  a32_map [1024];
	logic [1:0]  a24_map [4];
	logic        any_rst;
	assign any_rst = !aresetn || system_reset || local_reset;

	// pin synchroniser: stage one feeds stage two only
	localparam int PW = 50;
	logic [PW-1:0] pin_s1;
	logic [PW-1:0] pin_s2;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end
		else if (ce)
		begin
			pin_s1 <= {vme_strobe, vme_write, vme_addr_only, vme_block, vme_am,
				vme_addr, vme_lanes, ack_lines};
			pin_s2 <= pin_s1;
		end
	logic        p_strobe;
	logic        p_write;
	logic        p_ado;
	logic        p_blt;
	logic [1:0]  p_am;
	logic [31:0] p_addr;
	logic [3:0]  p_lanes;
	logic [7:0]  p_ack;
	assign {p_strobe, p_write, p_ado, p_blt, p_am, p_addr, p_lanes, p_ack} = pin_s2;

	// axi4-lite: address and data latched independently
	logic        aw_got;
	logic        w_got;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	assign s_awready = !aw_got && !s_bvalid;
	assign s_wready  = !w_got && !s_bvalid;
	assign s_arready = !s_rvalid;
	logic        do_write;
	assign do_write = aw_got && w_got && !s_bvalid;
	logic [1:0]  tbl;
	assign tbl = map_index[`TBL_HI:`TBL_LO];

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			aw_got   <= 1'b0;
			w_got    <= 1'b0;
			aw_addr  <= '0;
			w_data   <= '0;
			w_strb   <= '0;
			s_bvalid <= 1'b0;
			s_bresp  <= `RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_awvalid && s_awready)
			begin
				aw_got  <= 1'b1;
				aw_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_got  <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			if (do_write)
			begin
				aw_got   <= 1'b0;
				w_got    <= 1'b0;
				s_bvalid <= 1'b1;
				if (aw_addr > `OFF_MAP_DATA || aw_addr[1:0] != 2'h0)
					s_bresp <= `RESP_DECERR;
				else if (w_strb != 4'hf || aw_addr == `OFF_CONFIG)
					s_bresp <= `RESP_SLVERR;
				else
					s_bresp <= `RESP_OKAY;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end

	logic wr_ok;
	assign wr_ok = do_write && w_strb == 4'hf;

	// control register and map index; undefined bits are not stored
	always_ff @(posedge aclk)
		if (any_rst)
			ctrl <= `CS_RESET;
		else if (ce && wr_ok && aw_addr == `OFF_CTRL_STATUS)
			ctrl <= w_data[3:0];

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			addr_ext  <= `EXT_RESET;
			map_index <= `IDX_RESET;
		end
		else if (ce && wr_ok)
		begin
			if (aw_addr == `OFF_ADDR_EXT)
				addr_ext <= w_data[7:0];
			if (aw_addr == `OFF_MAP_INDEX)
				map_index <= w_data[11:0];
		end

	// decode maps: volatile, left unreset on purpose, valid bits guard them
	always_ff @(posedge aclk)
		if (ce && wr_ok && aw_addr == `OFF_MAP_DATA)
		begin
			case (tbl)
				`TBL_LOCAL: local_map[map_index[9:0]] <= w_data[1:0];
				`TBL_A32:   a32_map[map_index[9:0]]   <= w_data[1:0];
				`TBL_A24:   a24_map[map_index[1:0]]   <= w_data[1:0];
				default:    ;
			endcase
		end

	logic [1:0] map_rd;
	always_comb
	begin
		case (tbl)
			`TBL_LOCAL: map_rd = local_map[map_index[9:0]];
			`TBL_A32:   map_rd = a32_map[map_index[9:0]];
			`TBL_A24:   map_rd = a24_map[map_index[1:0]];
			default:    map_rd = 2'h0;
		endcase
	end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata  <= '0;
			s_rresp  <= `RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_arvalid && s_arready)
			begin
				s_rvalid <= 1'b1;
				s_rresp  <= `RESP_OKAY;
				case (s_araddr)
					`OFF_CTRL_STATUS: s_rdata <= {28'hfffffff, ctrl};
					`OFF_CONFIG:      s_rdata <= {24'hffffff, p_ack};
					`OFF_ADDR_EXT:    s_rdata <= {24'hffffff, addr_ext};
					`OFF_MAP_INDEX:   s_rdata <= {20'hfffff, map_index};
					`OFF_MAP_DATA:    s_rdata <= {30'h3fffffff, map_rd};
					default:
					begin
						s_rdata <= 32'hffffffff;
						s_rresp <= `RESP_DECERR;
					end
				endcase
			end
			else if (s_rvalid && s_rready)
				s_rvalid <= 1'b0;
		end

	// arbiter: index 0 vme slave, 1-4 code units, 5-8 data units
	logic [8:0] req;
	logic [8:0] blocked;
	logic [8:0] eligible;
	logic       vme_req;
	assign req      = {data_req, code_req, vme_req};
	assign eligible = req & ~blocked;

	function automatic logic [8:0] pick(input logic [8:0] e);
		logic [8:0] g;
		g = '0;
		for (int i = 8; i >= 0; i--)
			if (e[i])
				g = 9'h001 << i;
		return g;
	endfunction : pick

	always_ff @(posedge aclk)
		if (!aresetn)
			bus_grant <= '0;
		else if (ce)
		begin
			if ((bus_grant & req) == 9'h000)
				bus_grant <= pick(eligible);
		end

	// fairness latch on cache units only; vme never blocked
	always_ff @(posedge aclk)
		if (!aresetn)
			blocked <= '0;
		else if (ce)
		begin
			if ((req[8:1] & ~blocked[8:1]) == 8'h00 && (bus_grant & req) == 9'h000)
				blocked <= {bus_grant[8:1], 1'b0};
			else
				blocked <= blocked | {bus_grant[8:1], 1'b0};
		end

	// outbound decode
	logic [1:0] seg_space;
	space_t     next_space;
	logic       misalign;
	assign seg_space = local_map[out_addr[`SEG_HI:`SEG_LO]];
	assign misalign  = (out_size == 2'h1 && out_addr[0]) ||
		(out_size == 2'h2 && out_addr[1:0] != 2'h0);
	always_comb
	begin
		next_space = SP_UTILITY;
		if (ctrl[`CS_LDV])
			next_space = space_t'({1'b0, seg_space});
		if (next_space == SP_UTILITY && out_addr[31:16] == `A16_OUT_TAG)
			next_space = SP_A16;
	end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			out_done       <= 1'b0;
			out_space      <= SP_UTILITY;
			out_fault      <= 1'b0;
			out_parity_odd <= 1'b0;
		end
		else if (ce)
		begin
			out_done <= out_valid;
			if (out_valid)
			begin
				out_space <= next_space;
				// no unaligned or block cycles as master
				out_fault <= (next_space inside {SP_A32, SP_A24, SP_A16}) &&
					(misalign || out_block);
				out_parity_odd <= out_cpu_write && ctrl[`CS_WWP];
			end
		end

	// inbound slave
	slv_state_t state;
	logic       strobe_d;
	logic       rise;
	logic       hit;
	logic       snoop;
	logic [31:0] in_addr;
	logic        par_err;
	assign rise = p_strobe && !strobe_d;
	assign vme_req = state == SLV_WAIT_GNT || state == SLV_XFER;
	always_comb
	begin
		hit     = 1'b0;
		snoop   = 1'b0;
		in_addr = p_addr;
		case (p_am)
			`AM_A32:
			begin
				hit   = ctrl[`CS_VDV] && a32_map[p_addr[`SEG_HI:`SEG_LO]][0];
				snoop = a32_map[p_addr[`SEG_HI:`SEG_LO]][1];
			end
			`AM_A24:
			begin
				hit     = ctrl[`CS_VDV] && a24_map[p_addr[23:22]][0];
				snoop   = a24_map[p_addr[23:22]][1];
				in_addr = {addr_ext, p_addr[23:0]};
			end
			`AM_A16:
			begin
				hit     = 1'b1;
				in_addr = {`A16_IN_TAG, p_addr[15:0]};
			end
			default: ;
		endcase
		if (p_blt)
			hit = 1'b0;
	end

	// even parity per byte on reads
	always_comb
	begin
		par_err = 1'b0;
		for (int b = 0; b < 4; b++)
			par_err = par_err | (^mem_rdata[8*b +: 8] ^ mem_rpar[b]);
	end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			state          <= SLV_IDLE;
			strobe_d       <= 1'b0;
			mem_req        <= 1'b0;
			mem_addr       <= '0;
			mem_be         <= '0;
			mem_write      <= 1'b0;
			mem_snoop      <= 1'b0;
			mem_parity_odd <= 1'b0;
			vme_dtack      <= 1'b0;
			vme_berr       <= 1'b0;
		end
		else if (ce)
		begin
			strobe_d <= p_strobe;
			case (state)
				SLV_IDLE:
					if (rise && hit)
					begin
						if (p_ado)
						begin
							vme_dtack <= 1'b1;
							state     <= SLV_DONE;
						end
						else
						begin
							mem_addr  <= in_addr;
							mem_be    <= p_lanes;
							mem_write <= p_write;
							mem_snoop <= snoop && ctrl[`CS_VDV];
							mem_parity_odd <= 1'b0;
							state     <= SLV_WAIT_GNT;
						end
					end
				SLV_WAIT_GNT:
					if (!p_strobe)
						state <= SLV_IDLE;
					else if (bus_grant[0])
					begin
						mem_req <= 1'b1;
						state   <= SLV_XFER;
					end
				SLV_XFER:
					if (mem_done)
					begin
						mem_req <= 1'b0;
						if (!mem_write && par_err && ctrl[`CS_SLAVE_PARITY_ERROR_ENABLE])
							vme_berr <= 1'b1;
						else
							vme_dtack <= 1'b1;
						state <= SLV_DONE;
					end
				SLV_DONE:
					if (!p_strobe)
					begin
						vme_dtack <= 1'b0;
						vme_berr  <= 1'b0;
						mem_snoop <= 1'b0;
						state     <= SLV_IDLE;
					end
				default: state <= SLV_IDLE;
			endcase
		end

	a_arb_vme_first: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && req[0] && bus_grant == 9'h000 |=> bus_grant == 9'h001)
		else $error("vme request not granted first");
	a_arb_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
		$onehot0(bus_grant))
		else $error("more than one grant");
	a_fair_block: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (bus_grant & req) == 9'h000 |=> (bus_grant & $past(blocked)) == 9'h000)
		else $error("cache unit regranted unfairly");
	a_no_resp_invalid: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && state == SLV_IDLE && rise && !ctrl[`CS_VDV] && p_am != `AM_A16
		|=> state == SLV_IDLE)
		else $error("slave answered with vme decoder invalid");
	a_util_default: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && out_valid && !ctrl[`CS_LDV] |=> out_space inside {SP_UTILITY, SP_A16})
		else $error("non utility space with decoder invalid");
	a_a24_ext: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && state == SLV_IDLE && rise && hit && !p_ado && p_am == `AM_A24
		|=> mem_addr[31:24] == $past(addr_ext))
		else $error("a24 upper byte not from extension");
	a_berr_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(vme_berr) |-> $past(ctrl[`CS_SLAVE_PARITY_ERROR_ENABLE]) && !mem_write)
		else $error("bus error without parity enable");
	a_ctrl_reset: assert property (@(posedge aclk)
		system_reset || local_reset |=> ctrl == `CS_RESET)
		else $error("control not cleared by reset");
	a_wparity: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && out_valid && out_cpu_write |=> out_parity_odd == $past(ctrl[`CS_WWP]))
		else $error("cpu write parity wrong");
	c_inbound: cover property (@(posedge aclk) disable iff (!aresetn) $rose(vme_dtack));
	c_berr: cover property (@(posedge aclk) disable iff (!aresetn) $rose(vme_berr));
	c_snoop: cover property (@(posedge aclk) disable iff (!aresetn) mem_req && mem_snoop);
endmodule : vme_local_bus_bridge_control

// ---- dv/mem_partner.sv ----
// memory responder behind the inbound access path
`timescale 1ns/1ps
module mem_partner (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// knobs from the bench
	input  wire logic        slow,
	input  wire logic        bad_par,
	// memory port
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             mem_done,
	output logic [31:0]      mem_rdata,
	output logic [3:0]       mem_rpar
);
	logic [31:0] d;
	logic [2:0]  cnt;
	logic        busy;
	assign d = mem_addr ^ 32'h5a5a_a5a5;
	// data toggles outside the done pulse so a stale value never passes
	always_ff @(posedge aclk)
	begin
		mem_done  <= 1'b0;
		mem_rdata <= ~mem_rdata;
		mem_rpar  <= ~mem_rpar;
		if (!aresetn)
		begin
			busy      <= 1'b0;
			mem_rdata <= 32'h0;
			mem_rpar  <= 4'h0;
		end
		else if (!busy && mem_req && !mem_done)
		begin
			busy <= 1'b1;
			cnt  <= slow ? 3'h5 : 3'h0;
		end
		else if (busy && cnt != 3'h0)
			cnt <= cnt - 3'h1;
		else if (busy)
		begin
			busy      <= 1'b0;
			mem_done  <= 1'b1;
			mem_rdata <= d;
			mem_rpar  <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0] ^ bad_par};
		end
	end
endmodule : mem_partner

// ---- dv/tb_top.sv ----
// self-checking bench for the bridge control block
`timescale 1ns/1ps
`include "vme_bridge_defines.svh"
module tb_top;
	import vme_bridge_pkg::*;
	logic        aclk = 0, aresetn = 0, ce = 1, system_reset = 0, local_reset = 0;
	logic [11:0] s_awaddr = 0, s_araddr = 0;
	logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [31:0] s_wdata = 0, s_rdata, out_addr = 0, vme_addr = 0, mem_addr, mem_rdata;
	logic [3:0]  s_wstrb = 0, code_req = 0, data_req = 0, vme_lanes = 0, mem_be, mem_rpar;
	logic [1:0]  s_bresp, s_rresp, vme_am = 0, out_size = 0;
	logic [8:0]  bus_grant, g_prev;
	logic        out_valid = 0, out_block = 0, out_cpu_write = 0, out_done, out_fault;
	logic        out_parity_odd, vme_dtack, vme_berr, mem_req, mem_write, mem_snoop;
	logic        vme_strobe = 0, vme_write = 0, vme_addr_only = 0, vme_block = 0;
	logic        mem_parity_odd, mem_done, slow = 0, bad_par = 0, v_prev = 0;
	space_t      out_space;
	logic [7:0]  ack_lines = 0, ext;
	logic [31:0] a32, a24;
	logic [38:0] cap;
	logic [2:0]  es;
	int          n_errors = 0, checks_done = 0, seed = 32'h2d76ab1d;
	logic [33:0] q_r[$];
	logic [1:0]  q_b[$];
	logic [4:0]  q_o[$];
	logic [40:0] q_v[$];
	logic [8:0]  q_g[$];

	always #2.5 aclk = ~aclk;

	vme_local_bus_bridge_control DUT (.aclk, .aresetn, .ce, .system_reset, .local_reset,
		.s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready, .code_req, .data_req, .bus_grant, .out_valid,
		.out_addr, .out_size, .out_block, .out_cpu_write, .out_done, .out_space, .out_fault,
		.out_parity_odd, .vme_strobe, .vme_write, .vme_addr_only, .vme_block, .vme_am,
		.vme_addr, .vme_lanes, .ack_lines, .vme_dtack, .vme_berr, .mem_req, .mem_addr,
		.mem_be, .mem_write, .mem_snoop, .mem_parity_odd, .mem_done, .mem_rdata, .mem_rpar);
	mem_partner u_mem (.aclk, .aresetn, .slow, .bad_par, .mem_req, .mem_addr, .mem_done,
		.mem_rdata, .mem_rpar);

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	// one transfer; p holds the channels still pending: answer, address, data
	task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [33:0] ex);
		logic [2:0] p;
		logic [2:0] h;
		int         t;
		if (wr)
			q_b.push_back(ex[33:32]);
		else
			q_r.push_back(ex);
		p = wr ? 3'h7 : 3'h6;
		t = 0;
		s_awaddr  <= a;
		s_araddr  <= a;
		s_wdata   <= d;
		s_wstrb   <= st;
		s_awvalid <= wr;
		s_wvalid  <= wr;
		s_bready  <= wr;
		s_arvalid <= !wr;
		s_rready  <= !wr;
		while (p != 3'h0 && t < 100)
		begin
			@(negedge aclk);
			h = {wr ? s_bvalid : s_rvalid, wr ? s_awready : s_arready, s_wready} & p;
			@(posedge aclk);
			p = p & ~h;
			s_awvalid <= wr & p[1];
			s_wvalid  <= wr & p[0];
			s_bready  <= wr & p[2];
			s_arvalid <= !wr & p[1];
			s_rready  <= !wr & p[2];
			t++;
		end
		@(posedge aclk);
	endtask : axi

	task automatic ob(input logic [31:0] a, input logic [3:0] k, input logic [4:0] ex);
		q_o.push_back(ex);
		out_addr      <= a;
		out_size      <= k[3:2];
		out_block     <= k[1];
		out_cpu_write <= k[0];
		out_valid     <= 1'b1;
		@(posedge aclk);
		out_valid <= 1'b0;
		out_addr  <= ~a;
		@(posedge aclk);
	endtask : ob

	// k: answer expected, write, address only, block, bad read parity
	task automatic vme(input logic [4:0] k, input logic [1:0] am, input logic [31:0] a,
		input logic [3:0] ln, input logic [40:0] ex);
		int t;
		vme_write     <= k[3];
		vme_addr_only <= k[2];
		vme_block     <= k[1];
		bad_par       <= k[0];
		vme_am        <= am;
		vme_addr      <= a;
		vme_lanes     <= ln;
		slow          <= 1'($random(seed));
		@(posedge aclk);
		vme_strobe <= 1'b1;
		if (k[4])
			q_v.push_back(ex);
		for (t = 0; t < 40 && !(vme_dtack || vme_berr); t++)
			@(posedge aclk);
		if (!k[4])
			chk("no answer", 3'h0, {vme_dtack, vme_berr, mem_req});
		vme_strobe <= 1'b0;
		vme_addr   <= ~a;
		for (t = 0; t < 40 && (vme_dtack || vme_berr); t++)
			@(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask : vme

	task automatic arb(input logic [3:0] c, input logic [3:0] d, input logic [8:0] ex);
		q_g.push_back(ex);
		code_req <= c;
		data_req <= d;
		repeat (4) @(posedge aclk);
		code_req <= 4'h0;
		data_req <= 4'h0;
		repeat (6) @(posedge aclk);
	endtask : arb

	// result watcher: oldest note against each answer as it appears
	always @(posedge aclk)
	begin
		if (s_rvalid && s_rready)
			chk("rdata", q_r.pop_front(), {s_rresp, s_rdata});
		if (s_bvalid && s_bready)
			chk("bresp", q_b.pop_front(), s_bresp);
		if (out_done)
			chk("outbound", q_o.pop_front(), {out_space, out_fault, out_parity_odd});
		if (bus_grant != 9'h0 && g_prev == 9'h0 && !vme_strobe)
			chk("grant", q_g.pop_front(), bus_grant);
		if ((vme_dtack || vme_berr) && !v_prev)
			chk("inbound", q_v.pop_front(), {vme_berr, vme_dtack, cap});
		if (mem_req)
			cap <= {mem_addr, mem_be, mem_write, mem_snoop, mem_parity_odd};
		else if (!vme_strobe)
			cap <= '0;
		g_prev <= bus_grant;
		v_prev <= vme_dtack || vme_berr;
	end

	initial
	begin
		ack_lines = 8'($random(seed));
		ext       = 8'($random(seed));
		a32       = {10'h005, 20'($random(seed)), 2'b00};
		a24       = {8'($random(seed)), 2'h1, 22'($random(seed))};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi(0, `OFF_CTRL_STATUS, 0, 0, {2'h0, 32'hffff_fff0});
		axi(0, `OFF_CONFIG, 0, 0, {2'h0, 24'hffffff, ack_lines});
		axi(0, 12'h014, 0, 0, {2'h3, 32'hffff_ffff});
		axi(1, 12'h014, 0, 4'hf, {2'h3, 32'h0});
		axi(1, 12'h002, 0, 4'hf, {2'h3, 32'h0});
		axi(1, `OFF_CONFIG, 0, 4'hf, {2'h2, 32'h0});
		axi(1, `OFF_CTRL_STATUS, 32'hf, 4'h1, {2'h2, 32'h0});
		axi(1, `OFF_CTRL_STATUS, 32'h5a, 4'hf, 34'h0);
		axi(0, `OFF_CTRL_STATUS, 0, 0, {2'h0, 32'hffff_fffa});
		system_reset <= 1'b1;
		@(posedge aclk);
		system_reset <= 1'b0;
		axi(0, `OFF_CTRL_STATUS, 0, 0, {2'h0, 32'hffff_fff0});
		axi(1, `OFF_CTRL_STATUS, 32'h5, 4'hf, 34'h0);
		local_reset <= 1'b1;
		@(posedge aclk);
		local_reset <= 1'b0;
		axi(0, `OFF_CTRL_STATUS, 0, 0, {2'h0, 32'hffff_fff0});
		axi(1, `OFF_ADDR_EXT, {24'h0, ext}, 4'hf, 34'h0);
		axi(0, `OFF_ADDR_EXT, 0, 0, {2'h0, 24'hffffff, ext});
		$display("test done: registers");
		ob({10'h001, 22'h10}, 4'b1001, {SP_UTILITY, 2'b00});
		for (int i = 0; i < 4; i++)
		begin
			axi(1, `OFF_MAP_INDEX, {22'h0, 10'(i + 1)}, 4'hf, 34'h0);
			axi(1, `OFF_MAP_DATA, 32'((i + 2) % 4), 4'hf, 34'h0);
		end
		axi(1, `OFF_MAP_INDEX, 32'h3ff, 4'hf, 34'h0);
		axi(1, `OFF_MAP_DATA, 32'h0, 4'hf, 34'h0);
		axi(1, `OFF_CTRL_STATUS, 32'ha, 4'hf, 34'h0);
		for (int i = 0; i < 4; i++)
		begin
			es = 3'((i + 2) % 4);
			ob({10'(i + 1), 22'h0}, 4'b1000, {es, 2'b00});
		end
		ob(32'hffff_0010, 4'b0100, {SP_A16, 2'b00});
		ob({10'h001, 22'h2}, 4'b1000, {SP_A32, 2'b10});
		ob({10'h002, 22'h0}, 4'b1010, {SP_A24, 2'b10});
		ob({10'h004, 22'h1}, 4'b0001, {SP_DRAM, 2'b01});
		axi(1, `OFF_CTRL_STATUS, 32'h0, 4'hf, 34'h0);
		ob({10'h004, 22'h1}, 4'b0001, {SP_UTILITY, 2'b00});
		ce        <= 1'b0;
		out_valid <= 1'b1;
		@(posedge aclk);
		out_valid <= 1'b0;
		@(posedge aclk);
		chk("frozen", 1'b0, out_done);
		ce <= 1'b1;
		$display("test done: outbound decode");
		axi(1, `OFF_MAP_INDEX, 32'h405, 4'hf, 34'h0);
		axi(0, `OFF_MAP_INDEX, 0, 0, {2'h0, 32'hffff_f405});
		axi(1, `OFF_MAP_DATA, 32'h3, 4'hf, 34'h0);
		axi(1, `OFF_MAP_INDEX, 32'h406, 4'hf, 34'h0);
		axi(1, `OFF_MAP_DATA, 32'h0, 4'hf, 34'h0);
		axi(1, `OFF_MAP_INDEX, 32'h801, 4'hf, 34'h0);
		axi(1, `OFF_MAP_DATA, 32'h1, 4'hf, 34'h0);
		axi(1, `OFF_CTRL_STATUS, 32'hd, 4'hf, 34'h0);
		vme(5'b11000, 2'h2, a32, 4'hf, {2'b01, a32, 4'hf, 3'b110});
		vme(5'b10000, 2'h1, a24, 4'h6, {2'b01, ext, a24[23:0], 4'h6, 3'b000});
		vme(5'b11000, 2'h0, a32, 4'h3, {2'b01, 16'hfffe, a32[15:0], 4'h3, 3'b100});
		vme(5'b10100, 2'h2, a32, 4'hf, {2'b01, 39'h0});
		vme(5'b10001, 2'h1, a24, 4'hf, {2'b10, ext, a24[23:0], 4'hf, 3'b000});
		vme(5'b00010, 2'h2, a32, 4'hf, 41'h0);
		vme(5'b00000, 2'h2, {10'h006, a32[21:0]}, 4'hf, 41'h0);
		axi(1, `OFF_CTRL_STATUS, 32'h1, 4'hf, 34'h0);
		vme(5'b10001, 2'h1, a24, 4'hf, {2'b01, ext, a24[23:0], 4'hf, 3'b000});
		axi(1, `OFF_CTRL_STATUS, 32'h0, 4'hf, 34'h0);
		vme(5'b00000, 2'h2, a32, 4'hf, 41'h0);
		vme(5'b00000, 2'h1, a24, 4'hf, 41'h0);
		vme(5'b10000, 2'h0, a32, 4'hf, {2'b01, 16'hfffe, a32[15:0], 4'hf, 3'b000});
		$display("test done: inbound access");
		arb(4'b1010, 4'b1111, 9'h004);
		arb(4'h0, 4'b0110, 9'h040);
		arb(4'b1000, 4'b0001, 9'h010);
		// code unit 0 re-requests while data unit 0 holds: must wait its turn
		q_g.push_back(9'h002);
		q_g.push_back(9'h002);
		code_req <= 4'h1;
		data_req <= 4'h1;
		repeat (3) @(posedge aclk);
		code_req <= 4'h0;
		@(posedge aclk);
		code_req <= 4'h1;
		@(posedge aclk);
		data_req <= 4'h0;
		repeat (2) @(posedge aclk);
		chk("fair", 9'h000, bus_grant);
		code_req <= 4'h0;
		repeat (6) @(posedge aclk);
		$display("test done: arbitration");
		chk("notes left", 0, q_r.size() + q_b.size() + q_o.size() + q_v.size() + q_g.size());
		wrap_up();
	end

	initial
	begin
		#100000;
		n_errors++;
		wrap_up();
	end
endmodule : tb_top
